// *** test_tsf_ctrl.sv ***
// Purpose: self-checking bench for the ranging sensor control block
// Assumes: short boot and range counts set below
// Notes: random data bytes from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "tsf_cfg.svh"

module test_tsf_ctrl;
    localparam int BOOT = 400;
    localparam int RANGE = 300;
    localparam int LIMIT = 60000;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic shutdown_n = 1'b0;
    logic scl, pull, sda_o, sda_oe, irq_o, irq_oe;
    wire logic sda_w = ~(sda_oe | pull); // pull-up when nobody pulls
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    int seed;
    logic [15:0] base;
    logic [7:0] wq [4];
    logic [7:0] rq [4];

    // ====================
    // design and host
    tsf_ctrl #(.BOOT_CYCLES(BOOT), .RANGE_CYCLES(RANGE), .GEN_DEPTH(`TSF_GEN_DEPTH)) dut_u (
        .clk_in(clk_in), .nrst_in(nrst_in), .shutdown_n_in(shutdown_n), .scl_in(scl),
        .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
        .result_irq_n_out(irq_o), .result_irq_n_oe_out(irq_oe));
    tsf_host_model host_u (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_pull_out(pull));

    // clock
    always #4 clk_in = ~clk_in;

    // cycle ceiling against hangs
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            miscompares++;
            stop_test();
        end
    end

    // ====================
    // helpers
    function automatic logic [7:0] stat_exp(input logic irq, input logic run);
        stat_exp = 8'h00;
        stat_exp[`TSF_STAT_IRQ_BIT] = irq;
        stat_exp[`TSF_STAT_RUN_BIT] = run;
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // address then one more byte without a start; both acks as expected
    task automatic probe(input logic [7:0] adr, input logic nack);
        logic [7:0] d;
        logic a;
        host_u.start_c();
        host_u.xfer(adr, 1'b0, d, a);
        check("address ack", a, nack);
        host_u.xfer(8'h52, 1'b0, d, a);
        check("second ack", a, nack);
        host_u.stop_c();
    endtask

    // write message: address, index msb first, n data bytes
    task automatic wr(input logic [15:0] idx, input int cnt);
        logic [7:0] d;
        logic a;
        host_u.start_c();
        host_u.xfer(8'h52, 1'b0, d, a);
        check("write address ack", a, 1'b0);
        host_u.xfer(idx[15:8], 1'b0, d, a);
        host_u.xfer(idx[7:0], 1'b0, d, a);
        for (int i = 0; i < cnt; i++)
        begin
            host_u.xfer(wq[i], 1'b0, d, a);
            check("data ack", a, 1'b0);
        end
        host_u.stop_c();
    endtask

    // read message: index, repeated start, n bytes, last one refused
    task automatic rd(input logic [15:0] idx, input int cnt);
        logic [7:0] d;
        logic a;
        host_u.start_c();
        host_u.xfer(8'h52, 1'b0, d, a);
        host_u.xfer(idx[15:8], 1'b0, d, a);
        host_u.xfer(idx[7:0], 1'b0, d, a);
        host_u.start_c();
        host_u.xfer(8'h53, 1'b0, d, a);
        check("read address ack", a, 1'b0);
        for (int i = 0; i < cnt; i++)
        begin
            host_u.xfer(8'hFF, (i < cnt - 1), rq[i], a);
        end
        host_u.stop_c();
    endtask

    // bounded wait for the interrupt pin
    task automatic wait_irq();
        for (int i = 0; i < RANGE + 100 && irq_oe !== 1'b1; i++)
        begin
            @(negedge clk_in);
        end
        check("irq raised", irq_oe, 1'b1);
    endtask

    // ====================
    // main sequence
    initial
    begin
        seed = $urandom(67);
        repeat (2) @(negedge clk_in);
        nrst_in = 1'b1;
        repeat (20) @(negedge clk_in);
        probe(8'h52, 1'b1);
        shutdown_n = 1'b1;
        probe(8'h52, 1'b1);
        repeat (BOOT) @(negedge clk_in);
        probe(8'h54, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            n = (k == 0) ? 4 : 1 + $urandom_range(3);
            base = 16'(`TSF_GEN_BASE + $urandom_range(`TSF_GEN_DEPTH - n));
            if (k == 0)
                base = 16'(`TSF_GEN_BASE + `TSF_GEN_DEPTH - 4);
            for (int i = 0; i < n; i++)
                wq[i] = 8'($urandom);
            wr(base, n);
            rd(base, n);
            for (int i = 0; i < n; i++)
                check("register byte", rq[i], wq[i]);
        end
        rd(16'h0100, 2);
        check("unmapped byte", {rq[0], rq[1]}, 16'h0000);
        wq[0] = 8'h01;
        wr(`TSF_IDX_CTRL, 1);
        wait_irq();
        rd(`TSF_IDX_STATUS, 3);
        check("status", rq[0], stat_exp(1'b1, 1'b1));
        check("result", {rq[1], rq[2]}, 16'h0001);
        repeat (2 * RANGE) @(negedge clk_in);
        rd(`TSF_IDX_RES_HI, 2);
        check("held result", {rq[0], rq[1]}, 16'h0001);
        wr(`TSF_IDX_IRQ_CLR, 1);
        check("irq released", irq_oe, 1'b0);
        wait_irq();
        rd(`TSF_IDX_RES_HI, 2);
        check("next result", {rq[0], rq[1]}, 16'h0002);
        wq[0] = 8'h00;
        wr(`TSF_IDX_CTRL, 1);
        rd(`TSF_IDX_STATUS, 1);
        check("stopped status", rq[0], stat_exp(1'b1, 1'b0));
        wq[0] = 8'h01;
        wr(`TSF_IDX_IRQ_CLR, 1);
        repeat (2 * RANGE) @(negedge clk_in);
        check("no range after stop", irq_oe, 1'b0);
        shutdown_n = 1'b0;
        repeat (10) @(negedge clk_in);
        probe(8'h52, 1'b1);
        // power cycle with shutdown tied high: straight through boot
        shutdown_n = 1'b1;
        nrst_in = 1'b0;
        repeat (2) @(negedge clk_in);
        nrst_in = 1'b1;
        repeat (BOOT + 10) @(negedge clk_in);
        probe(8'h52, 1'b0);
        stop_test();
    end
endmodule // test_tsf_ctrl

`default_nettype wire

// *** tsf_cfg.svh ***
// Purpose: constants for the ranging sensor control block
// Assumes: 125 MHz core clock
// Notes: indices are 16-bit register indices on the serial bus
`ifndef TSF_CFG_SVH
`define TSF_CFG_SVH

// ==========================================================
// bus address and register indices
`define TSF_DEV_ADDR 7'h29
`define TSF_IDX_CTRL 16'h0000
`define TSF_IDX_IRQ_CLR 16'h0001
`define TSF_IDX_STATUS 16'h0002
`define TSF_IDX_RES_HI 16'h0003
`define TSF_IDX_RES_LO 16'h0004
`define TSF_GEN_BASE 16'h0010
`define TSF_GEN_DEPTH 16

// ==========================================================
// field positions and reset values
`define TSF_CTRL_RUN_BIT 0
`define TSF_IRQ_CLR_BIT 0
`define TSF_STAT_IRQ_BIT 0
`define TSF_STAT_RUN_BIT 1
`define TSF_PIN_RST 3'h3
`define TSF_RESULT_RST 16'h0000

// ==========================================================
// timing
`define TSF_CLK_PERIOD_NS 8
`define TSF_BOOT_TIME_NS 1200000
`define TSF_RANGE_TIME_NS 33000000
`define TSF_BOOT_CYCLES (`TSF_BOOT_TIME_NS / `TSF_CLK_PERIOD_NS)
`define TSF_RANGE_CYCLES (`TSF_RANGE_TIME_NS / `TSF_CLK_PERIOD_NS)
`define TSF_SETTLE_CYCLES 2'h3

`endif

// *** tsf_ctrl.sv ***
// Purpose: ranging sensor control: serial target port and device state machine
// Assumes: pins asynchronous to clk_in; bus clock far slower than clk_in
// Notes: measurement itself is modelled by a timer and a result counter
// Function
// - shutdown low holds hardware standby; rising starts boot; falling returns
// - start command enters continuous ranging; stop returns to software standby
// - next measurement begins automatically only after interrupt is cleared
// - boot completes within 1.2 ms; no commands accepted before
// - shutdown tied high goes from power-up through boot to standby
// - default ranging repeats every 33 ms, about 30 Hz
// - result raises open-drain low interrupt, also visible in status
// - uncleared interrupt holds ranging between measurements; a start command from software standby ignores it and overwrites the result
// - bus lines only driven low, released otherwise
// - answer address with write byte 0x52, read byte 0x53
// - bytes of eight bits, each followed by receiver acknowledge
// - sample incoming data on serial clock rising edges
// - start is data falling, stop data rising, while clock high
// - repeated start begins a new message, address re-evaluated
// - acknowledge own address by pulling data low; latch direction
// - write message sends 16-bit index after address
// - each data byte after index is acknowledged then stored
// - read loads indexed register, shifts out on falling clock edges
// - index increments by one after each data byte
// - multi-byte values ascend in index, most significant byte first
`timescale 1ns/1ps
`default_nettype none
`include "tsf_cfg.svh"

module tsf_ctrl
    import tsf_pkg::*;
#(
    parameter int BOOT_CYCLES = `TSF_BOOT_CYCLES,
    parameter int RANGE_CYCLES = `TSF_RANGE_CYCLES,
    parameter int GEN_DEPTH = `TSF_GEN_DEPTH
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // shutdown pin from host
    input wire logic shutdown_n_in,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // open-drain result interrupt
    output logic result_irq_n_out,
    output logic result_irq_n_oe_out
);

    localparam int AW = $clog2(GEN_DEPTH);

    // ==========================================================
    // pin synchronisation and edge detection
    tsf_pins_t pin_raw;
    tsf_pins_t pin;
    logic scl_q;
    logic sda_q;

    assign pin_raw = '{shutdown_n: shutdown_n_in, scl: scl_in, sda: sda_in};

    tsf_sync #(
        .WIDTH(3),
        .RST_VAL(`TSF_PIN_RST)
    ) u_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .d_in(pin_raw),
        .q_out(pin)
    );

    // previous levels for edges
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= pin.scl;
            sda_q <= pin.sda;
        end
    end

    // bus events
    wire scl_rise = pin.scl & ~scl_q;
    wire scl_fall = ~pin.scl & scl_q;
    wire start_det = scl_q & pin.scl & sda_q & ~pin.sda;
    wire stop_det = scl_q & pin.scl & ~sda_q & pin.sda;

    // ==========================================================
    // device state and bus target state
    tsf_dev_state_t state;
    tsf_dev_state_t next_state;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [1:0] settle;
    logic irq_pend;
    logic next_irq;
    logic run_cmd;
    logic [15:0] result;

    tsf_bus_phase_t phase;
    tsf_bus_phase_t next_phase;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [1:0] byte_no;
    logic [1:0] next_byte_no;
    logic rw;
    logic next_rw;
    logic [15:0] idx;
    logic [15:0] next_idx;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] next_tx;
    logic host_nack;
    logic next_nack;
    logic sda_drive;
    tsf_wr_t bus_wr;
    logic [7:0] gen_mem [GEN_DEPTH];

    // ==========================================================
    // register decode
    wire bus_on = (state == TSF_SW_STANDBY) | (state == TSF_RANGING) |
                  (state == TSF_HOLD);
    wire running = (state == TSF_RANGING) | (state == TSF_HOLD);
    wire addr_hit = rx_shift[7:1] == `TSF_DEV_ADDR;
    // shift only data bits; the ack bit must not disturb the byte
    wire rx_take = scl_rise & (phase == TSF_BUS_RX);
    wire wr_ctrl = bus_wr.en & (bus_wr.idx == `TSF_IDX_CTRL);
    wire start_cmd = wr_ctrl & bus_wr.data[`TSF_CTRL_RUN_BIT];
    wire stop_cmd = wr_ctrl & ~bus_wr.data[`TSF_CTRL_RUN_BIT];
    wire irq_clr = bus_wr.en & (bus_wr.idx == `TSF_IDX_IRQ_CLR) &
                   bus_wr.data[`TSF_IRQ_CLR_BIT];
    wire [15:0] rd_off = idx - `TSF_GEN_BASE;
    wire [15:0] wr_off = bus_wr.idx - `TSF_GEN_BASE;
    wire rd_gen_hit = rd_off < 16'(GEN_DEPTH);
    wire wr_gen_hit = bus_wr.en & (wr_off < 16'(GEN_DEPTH));
    wire [7:0] status_byte = {6'h00, running, irq_pend};

    // read data for the current index, result high byte first
    wire [7:0] rd_byte =
        (idx == `TSF_IDX_CTRL) ? {7'h00, run_cmd} :
        (idx == `TSF_IDX_STATUS) ? status_byte :
        (idx == `TSF_IDX_RES_HI) ? result[15:8] :
        (idx == `TSF_IDX_RES_LO) ? result[7:0] :
        rd_gen_hit ? gen_mem[rd_off[AW-1:0]] : 8'h00;

    // ==========================================================
    // bus target next-state logic
    always_comb
    begin
        next_phase = phase;
        next_bit_cnt = bit_cnt;
        next_byte_no = byte_no;
        next_rw = rw;
        next_idx = idx;
        next_tx = tx_shift;
        next_nack = host_nack;
        bus_wr = '0;
        if (!bus_on || stop_det)
        begin
            next_phase = TSF_BUS_IDLE;
        end
        else if (start_det)
        begin
            // new or repeated start re-reads the address
            next_phase = TSF_BUS_RX;
            next_bit_cnt = 4'h0;
            next_byte_no = 2'h0;
        end
        else
        begin
            unique case (phase)
                TSF_BUS_IDLE:
                begin
                    next_phase = TSF_BUS_IDLE;
                end
                TSF_BUS_RX:
                begin
                    if (scl_rise)
                    begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    else if (scl_fall && bit_cnt == 4'h8)
                    begin
                        next_bit_cnt = 4'h0;
                        if (byte_no != 2'h0)
                        begin
                            next_phase = TSF_BUS_ACK;
                        end
                        else if (addr_hit)
                        begin
                            next_phase = TSF_BUS_ACK;
                            next_rw = rx_shift[0];
                        end
                        else
                        begin
                            next_phase = TSF_BUS_IDLE;
                        end
                    end
                end
                TSF_BUS_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_phase = TSF_BUS_RX;
                        next_byte_no = (byte_no == 2'h3) ? 2'h3 : byte_no + 2'h1;
                        unique case (byte_no)
                            2'h0:
                            begin
                                if (rw)
                                begin
                                    next_phase = TSF_BUS_TX;
                                    next_tx = rd_byte;
                                end
                            end
                            2'h1: next_idx = {rx_shift, idx[7:0]};
                            2'h2: next_idx = {idx[15:8], rx_shift};
                            2'h3:
                            begin
                                bus_wr = '{en: 1'b1, idx: idx, data: rx_shift};
                                next_idx = idx + 16'h0001;
                            end
                        endcase
                    end
                end
                TSF_BUS_TX:
                begin
                    if (scl_rise)
                    begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_cnt == 4'h8)
                        begin
                            next_phase = TSF_BUS_HACK;
                            next_bit_cnt = 4'h0;
                            next_idx = idx + 16'h0001;
                        end
                        else
                        begin
                            next_tx = {tx_shift[6:0], 1'b1};
                        end
                    end
                end
                TSF_BUS_HACK:
                begin
                    if (scl_rise)
                    begin
                        next_nack = pin.sda;
                    end
                    else if (scl_fall)
                    begin
                        if (host_nack)
                        begin
                            next_phase = TSF_BUS_IDLE;
                        end
                        else
                        begin
                            next_phase = TSF_BUS_TX;
                            next_tx = rd_byte;
                        end
                    end
                end
            endcase
        end
    end

    // bus target registers
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            phase <= TSF_BUS_IDLE;
            bit_cnt <= 4'h0;
            byte_no <= 2'h0;
            rw <= 1'b0;
            idx <= 16'h0000;
            rx_shift <= 8'h00;
            tx_shift <= 8'hFF;
            host_nack <= 1'b1;
            sda_drive <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            bit_cnt <= next_bit_cnt;
            byte_no <= next_byte_no;
            rw <= next_rw;
            idx <= next_idx;
            rx_shift <= rx_take ? {rx_shift[6:0], pin.sda} : rx_shift;
            tx_shift <= next_tx;
            host_nack <= next_nack;
            sda_drive <= (next_phase == TSF_BUS_ACK) |
                         ((next_phase == TSF_BUS_TX) & ~next_tx[7]);
        end
    end

    // ==========================================================
    // general byte storage, one entry per index
    for (genvar g = 0; g < GEN_DEPTH; g++)
    begin : g_mem
        always_ff @(posedge clk_in or negedge nrst_in)
        begin
            if (!nrst_in)
                gen_mem[g] <= 8'h00;
            else if (wr_gen_hit && wr_off[AW-1:0] == AW'(g))
                gen_mem[g] <= bus_wr.data;
        end
    end

    // ==========================================================
    // device state machine
    always_comb
    begin
        next_state = state;
        if (state != TSF_POWER_UP && !pin.shutdown_n)
        begin
            next_state = TSF_HW_STANDBY;
        end
        else
        begin
            unique case (state)
                TSF_POWER_UP:
                    if (settle == `TSF_SETTLE_CYCLES)
                        next_state = pin.shutdown_n ? TSF_BOOT : TSF_HW_STANDBY;
                TSF_HW_STANDBY:
                    next_state = TSF_BOOT;
                TSF_BOOT:
                    if (cnt == 32'(BOOT_CYCLES - 1))
                        next_state = TSF_SW_STANDBY;
                TSF_SW_STANDBY:
                    if (start_cmd)
                        next_state = TSF_RANGING;
                TSF_RANGING:
                    if (stop_cmd)
                        next_state = TSF_SW_STANDBY;
                    else if (cnt == 32'(RANGE_CYCLES - 1))
                        next_state = TSF_HOLD;
                TSF_HOLD:
                    if (stop_cmd)
                        next_state = TSF_SW_STANDBY;
                    else if (!irq_pend)
                        next_state = TSF_RANGING;
            endcase
        end
    end

    // timer restarts on every state change
    wire timed = (state == TSF_BOOT) | (state == TSF_RANGING);
    wire meas_done = (state == TSF_RANGING) & (next_state == TSF_HOLD);
    wire enter_hw = next_state == TSF_HW_STANDBY;
    assign next_cnt = (next_state != state || !timed) ? 32'h0 : cnt + 32'h1;
    // set wins over clear
    assign next_irq = meas_done | (irq_pend & ~irq_clr & ~enter_hw);

    // device registers
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state <= TSF_POWER_UP;
            cnt <= 32'h0;
            settle <= 2'h0;
            irq_pend <= 1'b0;
            run_cmd <= 1'b0;
            result <= `TSF_RESULT_RST;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            settle <= (state == TSF_POWER_UP) ? settle + 2'h1 : settle;
            irq_pend <= next_irq;
            run_cmd <= enter_hw ? 1'b0 : (wr_ctrl ? bus_wr.data[0] : run_cmd);
            result <= meas_done ? result + 16'h0001 : result;
        end
    end

    // ==========================================================
    // open-drain outputs, driven low only
    assign sda_out = 1'b0;
    assign sda_oe_out = sda_drive;
    assign result_irq_n_out = 1'b0;
    assign result_irq_n_oe_out = irq_pend;

endmodule // tsf_ctrl

`default_nettype wire

// *** tsf_ctrl_assertions.sv ***
// Purpose: port checks for the ranging sensor control block
// Assumes: bus clock low for at least 10 core clocks per bit
// Notes: bound to every tsf_ctrl instance
`timescale 1ns/1ps
`default_nettype none

module tsf_ctrl_assertions #(
    parameter int BOOT_CYCLES = 20,
    parameter int RANGE_CYCLES = 200,
    parameter int GEN_DEPTH = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // host pins
    input wire logic shutdown_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    // device pins
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic result_irq_n_out,
    input wire logic result_irq_n_oe_out
);
    int hi_cnt;
    int lo_cnt;

    // ====================
    // helper counters
    // time since shutdown rose, time interrupt released
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            hi_cnt <= 0;
            lo_cnt <= 0;
        end
        else
        begin
            hi_cnt <= shutdown_n_in ? ((hi_cnt < BOOT_CYCLES) ? hi_cnt + 1 : hi_cnt) : 0;
            lo_cnt <= result_irq_n_oe_out ? 0 : ((lo_cnt < RANGE_CYCLES) ? lo_cnt + 1 : lo_cnt);
        end
    end

    // ====================
    // properties
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    a_sda_only_low: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_irq_only_low: assert property (result_irq_n_out == 1'b0)
        else $error("interrupt line driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("data drive changed while clock high");
    a_bit_stands: assert property ($rose(sda_oe_out) |-> sda_oe_out [*8])
        else $error("data drive shorter than a bit");
    a_standby_quiet: assert property (!shutdown_n_in [*6] |-> !sda_oe_out && !result_irq_n_oe_out)
        else $error("activity in hardware standby");
    a_boot_quiet: assert property (hi_cnt > 0 && hi_cnt < BOOT_CYCLES |-> !sda_oe_out)
        else $error("bus answered during boot");
    a_range_time: assert property ($rose(result_irq_n_oe_out) |-> lo_cnt >= RANGE_CYCLES - 1)
        else $error("measurement shorter than range time");
    a_irq_holds: assert property (result_irq_n_oe_out && scl_in && sda_in && shutdown_n_in |=> result_irq_n_oe_out)
        else $error("interrupt dropped without a clear");
    a_stop_release: assert property (scl_in && $rose(sda_in) |-> !sda_oe_out [*8])
        else $error("data driven after stop");

    // main scenarios
    c_irq_set: cover property ($rose(result_irq_n_oe_out));
    c_irq_clear: cover property ($fell(result_irq_n_oe_out) && shutdown_n_in);
    c_stop: cover property (scl_in && $rose(sda_in));
endmodule // tsf_ctrl_assertions

bind tsf_ctrl tsf_ctrl_assertions #(
    .BOOT_CYCLES(BOOT_CYCLES), .RANGE_CYCLES(RANGE_CYCLES), .GEN_DEPTH(GEN_DEPTH)
) chk_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .shutdown_n_in(shutdown_n_in),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .result_irq_n_out(result_irq_n_out), .result_irq_n_oe_out(result_irq_n_oe_out)
);

`default_nettype wire

// *** tsf_host_model.sv ***
// Purpose: bus master model driving the serial bus
// Assumes: bit period of 20 core clocks, 160 ns
// Notes: clock stands high between frames; data pulled low only
`timescale 1ns/1ps
`default_nettype none

module tsf_host_model (
    // clock
    input wire logic clk_in,
    // wire level
    input wire logic sda_in,
    // host drive
    output logic scl_out,
    output logic sda_pull_out
);
    // ====================
    // idle bus, both lines released
    initial
    begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end

    // quarter bit
    task automatic wt();
        repeat (5) @(negedge clk_in);
    endtask

    // start or repeated start: data falls with clock high
    task automatic start_c();
        sda_pull_out = 1'b0;
        wt();
        scl_out = 1'b1;
        wt();
        sda_pull_out = 1'b1;
        wt();
        scl_out = 1'b0;
    endtask

    // stop: data rises with clock high
    task automatic stop_c();
        sda_pull_out = 1'b1;
        wt();
        scl_out = 1'b1;
        wt();
        sda_pull_out = 1'b0;
        wt();
    endtask

    // one bit; data changes only while clock low
    task automatic bit_c(input logic low, output logic seen);
        wt();
        sda_pull_out = low;
        wt();
        scl_out = 1'b1;
        wt();
        seen = sda_in;
        wt();
        scl_out = 1'b0;
    endtask

    // byte msb first, then acknowledge bit
    task automatic xfer(input logic [7:0] tx, input logic ack_low,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            bit_c(~tx[i], rx[i]);
        end
        bit_c(ack_low, ack);
    endtask
endmodule // tsf_host_model

`default_nettype wire

// *** tsf_pkg.sv ***
// Purpose: types shared by the ranging sensor control block
// Assumes: nothing
// Notes: constants live in tsf_cfg.svh
package tsf_pkg;

    // ==========================================================
    // device power and ranging states
    typedef enum logic [2:0] {
        TSF_POWER_UP,
        TSF_HW_STANDBY,
        TSF_BOOT,
        TSF_SW_STANDBY,
        TSF_RANGING,
        TSF_HOLD
    } tsf_dev_state_t;

    // ==========================================================
    // serial bus byte phases
    typedef enum logic [2:0] {
        TSF_BUS_IDLE,
        TSF_BUS_RX,
        TSF_BUS_ACK,
        TSF_BUS_TX,
        TSF_BUS_HACK
    } tsf_bus_phase_t;

    // synchronised pin levels
    typedef struct packed {
        logic shutdown_n;
        logic scl;
        logic sda;
    } tsf_pins_t;

    // register write strobe
    typedef struct packed {
        logic en;
        logic [15:0] idx;
        logic [7:0] data;
    } tsf_wr_t;

endpackage

// *** tsf_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: each bit is an independent level
// Notes: reset value per bit chosen by parameter
`timescale 1ns/1ps
`default_nettype none

module tsf_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // levels
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta;

    // ==========================================================
    // one pair of flops per bit
    for (genvar g = 0; g < WIDTH; g++)
    begin : g_bit
        always_ff @(posedge clk_in or negedge nrst_in)
        begin
            if (!nrst_in)
            begin
                meta[g] <= RST_VAL[g];
                q_out[g] <= RST_VAL[g];
            end
            else
            begin
                meta[g] <= d_in[g];
                q_out[g] <= meta[g];
            end
        end
    end

endmodule // tsf_sync

`default_nettype wire
